/* hdl/pwm_pair.sv */
// one channel pair: two 8-bit channels or one joined 16-bit channel
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pwm_pair (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic joined,
   input wire logic [1:0] enable,
   input wire logic [1:0] polarity,
   input wire logic [1:0] align,
   input wire logic [1:0] pcm,
   input wire logic [15:0] period_in,
   input wire logic [15:0] duty_in,
   output logic [1:0] wave,
   output logic [15:0] count_out
);
   // low byte: even channel, high byte: odd channel
   pwm_pkg::word_t cnt;
   pwm_pkg::word_t next_cnt;
   pwm_pkg::word_t per_act;
   pwm_pkg::word_t next_per_act;
   pwm_pkg::word_t duty_act;
   pwm_pkg::word_t next_duty_act;
   pwm_pkg::word_t acc;
   pwm_pkg::word_t next_acc;
   logic [1:0] dir;
   logic [1:0] next_dir;
   logic [1:0] next_wave;

   // one step of a channel counter; returns {boundary, new count}
   function automatic logic [16:0] step(input logic [15:0] c, input logic [15:0] p,
                                        input logic ctr, input logic down);
      logic [15:0] n;
      logic b;
      n = c;
      b = 1'b0;
      if (!ctr) begin
         if (c >= p) begin // see (RULE9)
            n = 16'h0000;
            b = 1'b1;
         end else begin
            n = c + 16'h0001;
         end
      end else if (down) begin
         if (c == 16'h0000) begin
            n = (p == 16'h0000) ? 16'h0000 : 16'h0001;
            b = 1'b1;
         end else begin
            n = c - 16'h0001;
         end
      end else begin
         n = (c >= p) ? c - ((c == 16'h0000) ? 16'h0000 : 16'h0001) : c + 16'h0001;
      end
      return {b, n};
   endfunction : step

   // output level before polarity; compares against the latched values
   function automatic logic level(input logic [15:0] c, input logic [15:0] d,
                                  input logic [15:0] p, input logic ctr);
      if (d > p) begin
         return 1'b1; // see (RULE3)
      end
      return ctr ? (c < d) : (c < d); // see (RULE6)
   endfunction : level

   logic [16:0] s0;
   logic [16:0] s1;
   logic [16:0] sw;
   logic [16:0] sum_lo;
   logic [16:0] sum_hi;
   logic [16:0] sum_w;
   logic [1:0] raw;

   always_comb begin
      next_cnt = cnt;
      next_per_act = per_act;
      next_duty_act = duty_act;
      next_acc = acc;
      next_dir = dir;
      raw = 2'b00;
      s0 = step({8'h00, cnt[7:0]}, {8'h00, per_act[7:0]}, align[0], dir[0]);
      s1 = step({8'h00, cnt[15:8]}, {8'h00, per_act[15:8]}, align[1], dir[1]);
      sw = step(cnt, per_act, align[1], dir[1]);
      sum_lo = {9'h000, acc[7:0]} + {9'h000, duty_act[7:0]};
      sum_hi = {9'h000, acc[15:8]} + {9'h000, duty_act[15:8]};
      sum_w = {1'b0, acc} + {1'b0, duty_act};
      if (joined) begin // see (RULE7)
         // odd channel's settings govern the joined channel
         if (enable[1]) begin
            next_cnt = sw[15:0];
            if (align[1] && (cnt >= per_act) && !dir[1]) begin
               next_dir[1] = 1'b1;
            end
            if (sw[16]) begin // see (RULE10)
               next_per_act = period_in;
               next_duty_act = duty_in;
               next_dir[1] = 1'b0;
            end
            if (pcm[1]) begin // see (RULE4)
               next_acc = sum_w[15:0];
               raw[1] = sum_w[16];
            end else begin
               raw[1] = level(cnt, duty_act, per_act, align[1]);
            end
         end else begin
            next_cnt = 16'h0000;
            next_dir = 2'b00;
            next_per_act = period_in;
            next_duty_act = duty_in;
         end
      end else begin
         // independent 8-bit channels, each with its own counter
         if (enable[0]) begin // see (RULE2)
            next_cnt[7:0] = s0[7:0];
            if (align[0] && (cnt[7:0] >= per_act[7:0]) && !dir[0]) begin
               next_dir[0] = 1'b1;
            end
            if (s0[16]) begin // see (RULE10)
               next_per_act[7:0] = period_in[7:0];
               next_duty_act[7:0] = duty_in[7:0];
               next_dir[0] = 1'b0;
            end
            if (pcm[0]) begin // see (RULE4)
               next_acc[7:0] = sum_lo[7:0];
               raw[0] = sum_lo[8];
            end else begin
               raw[0] = level({8'h00, cnt[7:0]}, {8'h00, duty_act[7:0]},
                              {8'h00, per_act[7:0]}, align[0]);
            end
         end else begin
            next_cnt[7:0] = 8'h00;
            next_dir[0] = 1'b0;
            next_per_act[7:0] = period_in[7:0];
            next_duty_act[7:0] = duty_in[7:0];
         end
         if (enable[1]) begin
            next_cnt[15:8] = s1[7:0];
            if (align[1] && (cnt[15:8] >= per_act[15:8]) && !dir[1]) begin
               next_dir[1] = 1'b1;
            end
            if (s1[16]) begin
               next_per_act[15:8] = period_in[15:8];
               next_duty_act[15:8] = duty_in[15:8];
               next_dir[1] = 1'b0;
            end
            if (pcm[1]) begin
               next_acc[15:8] = sum_hi[7:0];
               raw[1] = sum_hi[8];
            end else begin
               raw[1] = level({8'h00, cnt[15:8]}, {8'h00, duty_act[15:8]},
                              {8'h00, per_act[15:8]}, align[1]);
            end
         end else begin
            next_cnt[15:8] = 8'h00;
            next_dir[1] = 1'b0;
            next_per_act[15:8] = period_in[15:8];
            next_duty_act[15:8] = duty_in[15:8];
         end
      end
      // joined pair drives the same waveform on both pins
      if (joined) begin
         next_wave = {2{raw[1] ^ polarity[1]}}; // see (RULE5)
      end else begin
         next_wave = raw ^ polarity; // see (RULE5)
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 16'h0000;
         per_act <= 16'hFFFF;
         duty_act <= 16'h0000;
         acc <= 16'h0000;
         dir <= 2'b00;
         wave <= 2'b00;
         count_out <= 16'h0000;
      end else begin
         cnt <= next_cnt;
         per_act <= next_per_act;
         duty_act <= next_duty_act;
         acc <= next_acc;
         dir <= next_dir;
         wave <= next_wave;
         count_out <= next_cnt;
      end
   end
endmodule : pwm_pair
`default_nettype wire

/* hdl/pwm_defs.svh */
// register offsets, address width and reset values for the pwm timer
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH
`define PWM_ADDR_W 6
`define PWM_REG_ENABLE 6'h00
`define PWM_REG_POLARITY 6'h01
`define PWM_REG_ALIGN 6'h02
`define PWM_REG_PCM 6'h03
`define PWM_REG_JOIN 6'h04
`define PWM_REG_PERIOD0 6'h08
`define PWM_REG_DUTY0 6'h10
`define PWM_REG_COUNT0 6'h18
`define PWM_REG_PINS 6'h20
`define PWM_PERIOD_RST 8'hFF
`define PWM_DUTY_RST 8'h00
`define PWM_CTRL_RST 8'h00
`define PWM_JOIN_RST 4'h0
`endif

/* hdl/pwm_pkg.sv */
// types shared by the pwm timer modules
package pwm_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      dir_up,
      dir_down
   } dir_t;
endpackage : pwm_pkg

/* hdl/pwm_cfg_if.sv */
// channel configuration bundle between register file and channel cores
`timescale 1ns/100ps
`default_nettype none
interface pwm_cfg_if;
   logic [7:0] enable;
   logic [7:0] polarity;
   logic [7:0] align;
   logic [7:0] pcm;
   logic [3:0] join_pair;
   pwm_pkg::byte_t period [8];
   pwm_pkg::byte_t duty [8];
   modport regs (output enable, polarity, align, pcm, join_pair, period, duty);
   modport core (input enable, polarity, align, pcm, join_pair, period, duty);
endinterface : pwm_cfg_if
`default_nettype wire

/* hdl/pwm_regs.sv */
// register file of the pwm timer on the plain strobe port
`timescale 1ns/100ps
`include "pwm_defs.svh"
`default_nettype none
module pwm_regs (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [63:0] counts,
   input wire logic [7:0] pins,
   pwm_cfg_if.regs cfg,
   output logic [7:0] rdata
);
   logic [7:0] next_rdata;
   pwm_pkg::byte_t per_r [8];
   pwm_pkg::byte_t duty_r [8];
   logic [7:0] en_r;
   logic [7:0] pol_r;
   logic [7:0] al_r;
   logic [7:0] pcm_r;
   logic [3:0] join_r;

   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `PWM_REG_ENABLE: next_rdata = en_r;
            `PWM_REG_POLARITY: next_rdata = pol_r;
            `PWM_REG_ALIGN: next_rdata = al_r;
            `PWM_REG_PCM: next_rdata = pcm_r;
            `PWM_REG_JOIN: next_rdata = {4'h0, join_r};
            `PWM_REG_PINS: next_rdata = pins;
            default: begin
               if (addr[5:3] == 3'd1) next_rdata = per_r[addr[2:0]];
               else if (addr[5:3] == 3'd2) next_rdata = duty_r[addr[2:0]];
               else if (addr[5:3] == 3'd3) next_rdata = counts[addr[2:0]*8 +: 8];
               else next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_r <= `PWM_CTRL_RST;
         pol_r <= `PWM_CTRL_RST;
         al_r <= `PWM_CTRL_RST;
         pcm_r <= `PWM_CTRL_RST;
         join_r <= `PWM_JOIN_RST;
         for (int i = 0; i < 8; i++) begin
            per_r[i] <= `PWM_PERIOD_RST;
            duty_r[i] <= `PWM_DUTY_RST;
         end
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
         if (wr) begin
            case (addr)
               `PWM_REG_ENABLE: en_r <= wdata;
               `PWM_REG_POLARITY: pol_r <= wdata;
               `PWM_REG_ALIGN: al_r <= wdata;
               `PWM_REG_PCM: pcm_r <= wdata;
               `PWM_REG_JOIN: join_r <= wdata[3:0]; // see (RULE8)
               default: begin
                  if (addr[5:3] == 3'd1) per_r[addr[2:0]] <= wdata;
                  else if (addr[5:3] == 3'd2) duty_r[addr[2:0]] <= wdata;
               end
            endcase
         end
      end
   end

   assign cfg.enable = en_r;
   assign cfg.polarity = pol_r;
   assign cfg.align = al_r;
   assign cfg.pcm = pcm_r;
   assign cfg.join_pair = join_r;
   assign cfg.period = per_r;
   assign cfg.duty = duty_r;
endmodule : pwm_regs
`default_nettype wire

/* hdl/eight_channel_pwm_timer.sv */
// top of the eight channel pwm timer
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (RULE1) there are eight channels with 8-bit period and duty each.
// (RULE2) each channel has its own counter, period and duty and runs alone.
// (RULE3) duty can be set anywhere from always low to always high. Always high needs duty above period, so not at period 255.
// (RULE4) a per channel pcm mode replaces the pulse waveform.
// (RULE5) each output level can be inverted per channel.
// (RULE6) each channel is left aligned or center aligned.
// (RULE7) pairs 7/6, 5/4, 3/2, 1/0 can be joined into 16-bit channels.
// (RULE8) joining is chosen per pair, any mix from 8/0 to 0/4.
// (RULE9) left aligned counts up and wraps at period; center counts up then down.
// (RULE10) new period and duty take effect only at the next period boundary.
module eight_channel_pwm_timer (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic [7:0] pwm_out
);
   pwm_cfg_if cfg ();
   logic [63:0] counts;
   logic [7:0] wave;

   pwm_regs u_regs (
      .core_clk(core_clk),
      .rstn(rstn),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .counts(counts),
      .pins(pwm_out),
      .cfg(cfg),
      .rdata(rdata)
   );

   // eight channels as four pair cores
   for (genvar g = 0; g < 4; g++) begin : g_pair // see (RULE1)
      pwm_pair u_pair (
         .core_clk(core_clk),
         .rstn(rstn),
         .joined(cfg.join_pair[g]),
         .enable(cfg.enable[2*g +: 2]),
         .polarity(cfg.polarity[2*g +: 2]),
         .align(cfg.align[2*g +: 2]),
         .pcm(cfg.pcm[2*g +: 2]),
         .period_in({cfg.period[2*g+1], cfg.period[2*g]}),
         .duty_in({cfg.duty[2*g+1], cfg.duty[2*g]}),
         .wave(wave[2*g +: 2]),
         .count_out(counts[16*g +: 16])
      );
   end

   // wave is already registered in the pair; pwm_out is a plain wire copy of that flop
   assign pwm_out = wave;
endmodule : eight_channel_pwm_timer
`default_nettype wire

/* testbench/pwm_timer_properties.sv */
// port checker of the pwm timer top, with its bind
`timescale 1ns/100ps
`default_nettype none
module pwm_timer_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [7:0] pwm_out
);
   logic [3:0] jn;
   logic [3:0] next_jn;
   always_comb begin
      next_jn = jn;
      if (wr && addr == 6'h04) begin
         next_jn = wdata[3:0];
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         jn <= 4'h0;
      end else begin
         jn <= next_jn;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence mode_wr_rd;
      wr && addr >= 6'h01 && addr <= 6'h03 ##1 rd && addr == $past(addr);
   endsequence
   reset_quiet_a: assert property ($rose(rstn) |-> pwm_out == 8'h00 && rdata == 8'h00)
      else $error("outputs not low after reset");
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data without read");
   unmapped_read_a: assert property (rd && addr inside {[6'h05:6'h07], [6'h21:6'h3f]}
      |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   enable_readback_a: assert property (wr && addr == 6'h00 ##1 rd && addr == 6'h00
      |=> rdata == $past(wdata, 2))
      else $error("enable readback wrong");
   mode_readback_a: assert property (mode_wr_rd |=> rdata == $past(wdata, 2))
      else $error("mode readback wrong");
   join_readback_a: assert property (wr && addr == 6'h04 ##1 rd && addr == 6'h04
      |=> rdata == ($past(wdata, 2) & 8'h0f))
      else $error("join readback wrong");
   pins_read_a: assert property (rd && addr == 6'h20
      |=> rdata == $past(pwm_out))
      else $error("pin state readback wrong");
   // a join change may take a cycle or two to settle
   join_pins_a: assert property ($stable(jn) && $past(jn, 2) == jn
      |-> (((pwm_out[7] ^ pwm_out[6]) & jn[3]) | ((pwm_out[5] ^ pwm_out[4]) & jn[2])
      | ((pwm_out[3] ^ pwm_out[2]) & jn[1]) | ((pwm_out[1] ^ pwm_out[0]) & jn[0])) == 1'b0)
      else $error("joined pins differ");
   cover property (mode_wr_rd);
   cover property (rd && addr == 6'h20);
   cover property (jn[0] && pwm_out[0]);
endmodule : pwm_timer_checker
bind eight_channel_pwm_timer pwm_timer_checker chk (.core_clk(core_clk), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm_out(pwm_out));
`default_nettype wire

/* testbench/eight_channel_pwm_timer_tb_top.sv */
// register level bench of the pwm timer
`timescale 1ns/100ps
`default_nettype none
module eight_channel_pwm_timer_tb_top;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [7:0] pwm_out;
   logic [7:0] v;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   eight_channel_pwm_timer dut (.core_clk(core_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm_out(pwm_out));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         final_report;
      end
   end
   // the write strobe stays up between calls so back to back writes never drop it
   task wr_reg(input logic [5:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge core_clk);
   endtask : wr_reg
   task rd_reg(input logic [5:0] a);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      v = rdata;
      @(posedge core_clk);
   endtask : rd_reg
   task idle(input int c);
      wr <= 1'b0;
      repeat (c) @(posedge core_clk);
   endtask : idle
   // skips the partial run in progress, then times one whole run
   task run_len(input int ch, input logic lvl);
      int t;
      n = 0;
      t = 0;
      // settle off the launching edge before the first look at the pin
      @(negedge core_clk);
      while (pwm_out[ch] === lvl && t < 3000) begin
         @(negedge core_clk);
         t++;
      end
      while (pwm_out[ch] !== lvl && t < 3000) begin
         @(negedge core_clk);
         t++;
      end
      while (pwm_out[ch] === lvl && t < 3000) begin
         @(negedge core_clk);
         n++;
         t++;
      end
      @(posedge core_clk);
   endtask : run_len
   task hi_cnt(input int ch, input int c);
      n = 0;
      repeat (c) begin
         @(negedge core_clk);
         if (pwm_out[ch] === 1'b1) n++;
      end
      @(posedge core_clk);
   endtask : hi_cnt
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (int a = 0; a < 5; a++) begin
         rd_reg(a[5:0]);
         `CHK("ctrl reset", 8'h00, v)
         wr_reg(a[5:0], 8'h5a);
         rd_reg(a[5:0]);
         `CHK("ctrl", (a == 4) ? 8'h0a : 8'h5a, v)
         wr_reg(a[5:0], 8'h00);
      end
      for (int c = 0; c < 8; c++) begin
         rd_reg(6'h08 + c[5:0]);
         `CHK("period reset", 8'hff, v)
         rd_reg(6'h10 + c[5:0]);
         `CHK("duty reset", 8'h00, v)
      end
      $display("test registers done");
      wr_reg(6'h08, 8'h0f);
      wr_reg(6'h10, 8'h05);
      wr_reg(6'h09, 8'h0f);
      wr_reg(6'h11, 8'h09);
      wr_reg(6'h00, 8'h03);
      idle(40);
      run_len(0, 1'b1);
      `CHK("left run ch0", 5, n)
      run_len(1, 1'b1);
      `CHK("left run ch1", 9, n)
      // a duty change mid period must wait for the period boundary
      do @(negedge core_clk); while (pwm_out[0] !== 1'b0);
      do @(negedge core_clk); while (pwm_out[0] !== 1'b1);
      @(posedge core_clk);
      wr_reg(6'h10, 8'h0a);
      wr <= 1'b0;
      hi_cnt(0, 12);
      `CHK("deferred duty", 3, n)
      run_len(0, 1'b1);
      `CHK("new duty run", 10, n)
      wr_reg(6'h10, 8'h05);
      wr_reg(6'h01, 8'h01);
      idle(40);
      run_len(0, 1'b0);
      `CHK("inverted run", 5, n)
      wr_reg(6'h01, 8'h00);
      wr_reg(6'h02, 8'h01);
      idle(80);
      run_len(0, 1'b1);
      `CHK("center run", 9, n)
      $display("test waveform done");
      wr_reg(6'h0b, 8'h10);
      wr_reg(6'h13, 8'hff);
      wr_reg(6'h00, 8'h0c);
      idle(40);
      hi_cnt(2, 300);
      `CHK("duty zero", 0, n)
      hi_cnt(3, 300);
      `CHK("duty full", 300, n)
      rd_reg(6'h20);
      `CHK("pin state", 8'h08, v & 8'h0c)
      wr_reg(6'h14, 8'h40);
      wr_reg(6'h03, 8'h10);
      wr_reg(6'h00, 8'h10);
      idle(40);
      hi_cnt(4, 256);
      `CHK("pcm density", 64, n)
      $display("test duty and pcm done");
      wr_reg(6'h00, 8'h00);
      wr_reg(6'h02, 8'h00);
      wr_reg(6'h04, 8'h01);
      wr_reg(6'h08, 8'h00);
      wr_reg(6'h09, 8'h02);
      wr_reg(6'h10, 8'h02);
      wr_reg(6'h11, 8'h01);
      wr_reg(6'h00, 8'h02);
      idle(40);
      run_len(0, 1'b1);
      `CHK("joined run ch0", 258, n)
      run_len(1, 1'b1);
      `CHK("joined run ch1", 258, n)
      $display("test joined done");
      wr_reg(6'h3f, 8'haa);
      rd_reg(6'h3f);
      `CHK("unmapped", 8'h00, v)
      wr_reg(6'h1f, 8'h55);
      rd_reg(6'h1f);
      `CHK("counter read only", 8'h00, v)
      $display("test refusals done");
      final_report;
   end
endmodule : eight_channel_pwm_timer_tb_top
`default_nettype wire
